// [hw/gpio_defines.svh]
// Register offsets, reset values and widths for the I/O port block.
// Assumes an 8-bit data-memory address and data bus.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH
`define PORT_A_DATA_ADDR   8'h12
`define PORT_A_DIR_ADDR    8'h13
`define PORT_B_DATA_ADDR   8'h14
`define PORT_B_DIR_ADDR    8'h15
`define PORT_C_DATA_ADDR   8'h16
`define PORT_C_DIR_ADDR    8'h17
`define PORT_D_DATA_ADDR   8'h18
`define PORT_D_DIR_ADDR    8'h19
`define DUTY_VALUE_ADDR    8'h1A
`define DIR_RESET          8'hFF
`define LATCH_RESET        8'hFF
`define DUTY_RESET         8'h00
`define PORT_A_MASK        8'hFF
`define PORT_B_MASK        8'hFF
`define PORT_C_MASK        8'h03
`define PORT_D_MASK        8'h0F
`define PWM_CYCLE_CLOCKS   256
`define MOD_62_CLOCKS      64
`define MOD_71_CLOCKS      128
`define WAKE_SETTLE        3'h5
`endif

// [hw/gpio_pkg.sv]
// Types shared by the I/O port block.
// Assumes nothing beyond a SystemVerilog compiler.
package gpio_pkg;
  typedef enum logic [1:0]
  {
    PWM_MODE_62 = 2'h1,
    PWM_MODE_71 = 2'h2
  } pwm_mode_t;
  typedef enum logic [3:0]
  {
    OP_NONE = 4'h1,
    OP_SET  = 4'h2,
    OP_CLR  = 4'h4,
    OP_CPL  = 4'h8
  } rmw_op_t;
endpackage

// [hw/gpio_ports.sv]
// Four I/O ports with data latches, direction registers, bit
// operations, divider output on port A bit 3 and PWM on port D bit 0.
// Assumes a CPU data-memory bus on clk and a timer overflow pulse.
`include "gpio_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RL1 - Port data registers A to D at 12H, 14H, 16H, 18H; 22 lines.
// RL2 - Port reads are not latched; they return the sampled pin state.
// RL3 - Output latch holds its value until software rewrites it.
// RL4 - Per-bit direction registers at 13H, 15H, 17H, 19H.
// RL5 - Direction bit 1 is input; bit 0 drives latched value.
// RL6 - Read gives pin for input bits, latch for output bits.
// RL7 - After reset all lines are non-driving inputs.
// RL8 - Set, clear, complement read the port, modify, and write back.
// RL9 - Any port A line change produces a wake-up request.
// RL10 - Each port has a build-time pull-high option.
// RL11 - Port A bits 3, 4, 5 shared with divider, timer, interrupt.
// RL12 - Divider appears on port A bit 3 only in output mode.
// RL13 - Divider output gated by port A bit 3 latch only.
// RL14 - Divider output toggles on every timer overflow.
// RL15 - PWM on port D bit 0 when output mode and latch is 1.
// RL16 - PWM mode (6+2) or (7+1) set by build-time option.
// RL17 - Duty value register at 1AH; PWM counter runs on system clock.
// RL18 - (6+2): four 64-clock cycles, coarse bits 7..2, fine bits 1..0.
// RL19 - (7+1): two 128-clock cycles, coarse bits 7..1, fine bit 0.
// RL20 - PWM period is 256 clocks; total high time equals duty value.
// RL21 - Analog-selected port B lines lose digital function and pull-high.
// RL22 - Cycle i high coarse+1 clocks if i below fine, else coarse.
// RL23 - Direction resets to all ones; analog port B lines read zero.
module gpio_ports
  import gpio_pkg::*;
#(
  parameter logic      DIVIDER_EN = 1'b1,        // Divider option
  parameter logic      PWM_EN     = 1'b1,        // PWM option
  parameter pwm_mode_t PWM_MODE   = PWM_MODE_62, // PWM resolution
  parameter logic [3:0] PULL_EN   = 4'hF         // Pull-high per port
)
(
  input  wire logic        clk,          // System clock
  input  wire logic        sys_rst,      // Sync reset, high
  input  wire logic [7:0]  mem_addr,     // Data-memory address
  input  wire logic        mem_wr,       // Write strobe
  input  wire logic [7:0]  mem_wdata,    // Write data
  input  wire logic        mem_rd,       // Read strobe
  input  wire rmw_op_t     mem_op,       // Bit operation with write
  input  wire logic [2:0]  mem_bit,      // Bit index for set or clear
  output logic      [7:0]  mem_rdata,    // Read data
  input  wire logic        timer_ovf,    // Timer overflow pulse
  input  wire logic        timer_on,     // Timer running
  input  wire logic [2:0]  converter_control_cfg, // Port B config field
  input  wire logic [21:0] pin_in,       // Pin levels
  output logic      [21:0] pin_out,      // Pin drive values
  output logic      [21:0] pin_oe,       // Pin drive enables
  output logic      [21:0] pull_en,      // Pull-high enables
  output logic      [7:0]  port_a_in,    // Port A sync levels
  output logic             wake_req      // Port A wake-up request
);

  localparam int NBITS = 22;

  logic [7:0]  port_a_data_r, port_b_data_r, port_c_data_r, port_d_data_r;
  logic [7:0]  port_a_direction_r, port_b_direction_r;
  logic [7:0]  port_c_direction_r, port_d_direction_r;
  logic [7:0]  duty_value_r;
  logic [21:0] sync1_r, sync2_r, sync3_r, pin_state_r;
  logic        freq_divider_out_r;
  logic [7:0]  pwm_cnt_r;
  logic        pwm_r;
  logic [7:0]  analog_mask;
  logic [7:0]  rd_word;
  logic [7:0]  wr_word;
  logic [21:0] lat_flat, dir_flat, out_nxt, oe_nxt;
  logic [7:0]  mod_pos, coarse_duty;
  logic        fine_extra;
  logic [2:0]  settle_r;

  // Mask of port B lines taken as analog for a config code
  function automatic logic [7:0] analog_lines(input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    case (cfg)
      3'h0:    m = 8'h00;
      3'h1:    m = 8'h01;
      3'h2:    m = 8'h03;
      3'h3:    m = 8'h07;
      3'h4:    m = 8'h0F;
      3'h5:    m = 8'h1F;
      3'h6:    m = 8'h3F;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction

  // Input bits return pin, output bits return latch
  function automatic logic [7:0] port_view(input logic [7:0] lat,
                                           input logic [7:0] dir,
                                           input logic [7:0] pin);
    return (dir & pin) | (~dir & lat);
  endfunction

  assign analog_mask = analog_lines(converter_control_cfg); // RL21

  // Pin synchroniser, three stages
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 22'h000000;
      sync2_r <= 22'h000000;
      sync3_r <= 22'h000000;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A change counts once stages 2 and 3 agree
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pin_state_r <= 22'h000000;
    else
      for (int i = 0; i < NBITS; i++)
        if (sync2_r[i] == sync3_r[i])
          pin_state_r[i] <= sync3_r[i]; // RL2
  end

  // Whole-port value seen by a read or a bit operation
  always_comb
  begin
    rd_word = 8'h00;
    case (mem_addr)
      `PORT_A_DATA_ADDR:
        rd_word = port_view(port_a_data_r, port_a_direction_r, pin_state_r[7:0]); // RL6
      `PORT_B_DATA_ADDR:
        rd_word = port_view(port_b_data_r, port_b_direction_r, pin_state_r[15:8])
                  & ~analog_mask; // RL23
      `PORT_C_DATA_ADDR:
        rd_word = port_view(port_c_data_r, port_c_direction_r,
                            {6'h00, pin_state_r[17:16]}) & `PORT_C_MASK;
      `PORT_D_DATA_ADDR:
        rd_word = port_view(port_d_data_r, port_d_direction_r,
                            {4'h0, pin_state_r[21:18]}) & `PORT_D_MASK;
      `PORT_A_DIR_ADDR: rd_word = port_a_direction_r;
      `PORT_B_DIR_ADDR: rd_word = port_b_direction_r;
      `PORT_C_DIR_ADDR: rd_word = port_c_direction_r & `PORT_C_MASK;
      `PORT_D_DIR_ADDR: rd_word = port_d_direction_r & `PORT_D_MASK;
      `DUTY_VALUE_ADDR: rd_word = duty_value_r;
      default:          rd_word = 8'h00;
    endcase
  end

  // Read-modify-write: port read, bit set or cleared or whole port complemented, result written back
  always_comb
  begin
    wr_word = mem_wdata;
    case (mem_op)
      OP_SET:  wr_word = rd_word | (8'h01 << mem_bit); // RL8
      OP_CLR:  wr_word = rd_word & ~(8'h01 << mem_bit); // RL8
      OP_CPL:  wr_word = ~rd_word; // RL8
      OP_NONE: wr_word = mem_wdata;
      default: wr_word = mem_wdata;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_rdata <= 8'h00;
    else if (mem_rd)
      mem_rdata <= rd_word;
  end

  // Data latches hold until rewritten
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_a_data_r <= `LATCH_RESET;
      port_b_data_r <= `LATCH_RESET;
      port_c_data_r <= `LATCH_RESET;
      port_d_data_r <= `LATCH_RESET;
    end
    else if (mem_wr)
    begin
      case (mem_addr)
        `PORT_A_DATA_ADDR: port_a_data_r <= wr_word; // RL1 RL3
        `PORT_B_DATA_ADDR: port_b_data_r <= wr_word; // RL1 RL3
        `PORT_C_DATA_ADDR: port_c_data_r <= wr_word & `PORT_C_MASK; // RL1 RL3
        `PORT_D_DATA_ADDR: port_d_data_r <= wr_word & `PORT_D_MASK; // RL1 RL3
        default: ;
      endcase
    end
  end

  // Duty value for the PWM generator
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      duty_value_r <= `DUTY_RESET;
    else if (mem_wr && (mem_addr == `DUTY_VALUE_ADDR))
      duty_value_r <= wr_word; // RL17
  end

  // Direction registers; reset makes every line an input
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_a_direction_r <= `DIR_RESET; // RL7 RL23
      port_b_direction_r <= `DIR_RESET;
      port_c_direction_r <= `DIR_RESET;
      port_d_direction_r <= `DIR_RESET;
    end
    else if (mem_wr)
    begin
      case (mem_addr)
        `PORT_A_DIR_ADDR: port_a_direction_r <= wr_word; // RL4
        `PORT_B_DIR_ADDR: port_b_direction_r <= wr_word; // RL4
        `PORT_C_DIR_ADDR: port_c_direction_r <= wr_word | ~`PORT_C_MASK; // RL4
        `PORT_D_DIR_ADDR: port_d_direction_r <= wr_word | ~`PORT_D_MASK; // RL4
        default: ;
      endcase
    end
  end

  // Divider toggles on each overflow while the latch enables it
  // With the timer stopped the output holds its level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      freq_divider_out_r <= 1'b0;
    else if (!port_a_data_r[3])
      freq_divider_out_r <= 1'b0; // RL13
    else if (timer_ovf && timer_on)
      freq_divider_out_r <= ~freq_divider_out_r; // RL14
  end

  // PWM counter: 256-clock period from the system clock
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pwm_cnt_r <= 8'h00;
    else
      pwm_cnt_r <= pwm_cnt_r + 8'h01; // RL17 RL20
  end

  // Split counter and duty value by resolution mode
  always_comb
  begin
    mod_pos     = 8'h00;
    coarse_duty = 8'h00;
    fine_extra  = 1'b0;
    case (PWM_MODE) // RL16
      PWM_MODE_62:
      begin
        mod_pos     = {2'h0, pwm_cnt_r[5:0]};
        coarse_duty = {2'h0, duty_value_r[7:2]}; // RL18
        fine_extra  = pwm_cnt_r[7:6] < duty_value_r[1:0]; // RL18 RL22
      end
      PWM_MODE_71:
      begin
        mod_pos     = {1'b0, pwm_cnt_r[6:0]};
        coarse_duty = {1'b0, duty_value_r[7:1]}; // RL19
        fine_extra  = pwm_cnt_r[7] < duty_value_r[0]; // RL19 RL22
      end
      default:
      begin
        mod_pos     = 8'h00;
        coarse_duty = 8'h00;
        fine_extra  = 1'b0;
      end
    endcase
  end

  // High for coarse clocks, one more in the early modulation cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pwm_r <= 1'b0;
    else
      pwm_r <= ({1'b0, mod_pos} < ({1'b0, coarse_duty} + {8'h00, fine_extra})); // RL22
  end

  // Latches and directions as one 22-line vector
  assign lat_flat = {port_d_data_r[3:0], port_c_data_r[1:0], port_b_data_r, port_a_data_r};
  assign dir_flat = {port_d_direction_r[3:0], port_c_direction_r[1:0],
                     port_b_direction_r, port_a_direction_r};

  // Pin drive: direction 0 drives the latch as CMOS output
  always_comb
  begin
    oe_nxt  = ~dir_flat; // RL5
    out_nxt = lat_flat; // RL5
    oe_nxt[15:8] = ~port_b_direction_r & ~analog_mask; // RL21
    // Divider replaces the latch on port A bit 3
    if (DIVIDER_EN)
      out_nxt[3] = freq_divider_out_r; // RL11 RL12
    // PWM waveform gated by the port D bit 0 latch
    if (PWM_EN)
      out_nxt[18] = port_d_data_r[0] & pwm_r; // RL15
  end

  // Pull-high per port option; analog port B lines lose theirs
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_pull
      localparam int LO = (p == 0) ? 0 : (p == 1) ? 8 : (p == 2) ? 16 : 18;
      localparam int W  = (p == 0) ? 8 : (p == 1) ? 8 : (p == 2) ? 2 : 4;
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          pull_en[LO +: W] <= PULL_EN[p] ? {W{1'b1}} : {W{1'b0}}; // RL10
        else if (p == 1)
          pull_en[LO +: W] <= PULL_EN[p] ? W'(~analog_mask) : {W{1'b0}}; // RL21
        else
          pull_en[LO +: W] <= PULL_EN[p] ? {W{1'b1}} : {W{1'b0}}; // RL10
      end
    end
  endgenerate

  // Registered pin drive values
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pin_out <= 22'h000000;
    else
      pin_out <= out_nxt;
  end

  // Registered pin drive enables
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pin_oe <= 22'h000000; // RL7
    else
      pin_oe <= oe_nxt;
  end

  // Counts out the synchroniser fill so reset gives no false wake-up
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      settle_r <= 3'h0;
    else if (settle_r != `WAKE_SETTLE)
      settle_r <= settle_r + 3'h1;
  end

  // Port A levels for the timer and interrupt inputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      port_a_in <= 8'h00;
    else
      port_a_in <= pin_state_r[7:0]; // RL11
  end

  // Any port A change asks for wake-up once the chain has filled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wake_req <= 1'b0;
    else
      wake_req <= (settle_r == `WAKE_SETTLE) && (|(pin_state_r[7:0] ^ port_a_in)); // RL9
  end

endmodule

`default_nettype wire

// [verif/gpio_pins_model.sv]
// Board side of the 22 port pins: resolves drive, pull and float.
// Assumes the block's drive, enable and pull outputs.
`timescale 1ns/100ps
`default_nettype none
module gpio_pins_model
(
  input  wire logic        clk,     // Clock
  input  wire logic [21:0] pin_out, // Drive values
  input  wire logic [21:0] pin_oe,  // Drive enables
  input  wire logic [21:0] pull_en, // Pull enables
  input  wire logic [21:0] ext_val, // Board values
  input  wire logic [21:0] ext_en,  // Board enables
  output logic      [21:0] pin_in   // Pin levels
);
  logic [21:0] float_r = 22'h155555;
  // Undriven, unpulled lines wander every cycle
  always_ff @(posedge clk)
  begin
    float_r <= ~float_r;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_en | float_r));
endmodule
`default_nettype wire

// [verif/gpio_ports_bench.sv]
// Self-checking bench for the I/O port block.
// Assumes default build options: divider, PWM (6+2), pulls on.
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_bench;
  import gpio_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  mem_addr = 8'h00;
  logic        mem_wr = 1'b0;
  logic [7:0]  mem_wdata = 8'h00;
  logic        mem_rd = 1'b0;
  rmw_op_t     mem_op = OP_NONE;
  logic [2:0]  mem_bit = 3'h0;
  logic [7:0]  mem_rdata;
  logic        timer_ovf = 1'b0;
  logic        timer_on = 1'b0;
  logic [2:0]  cfg = 3'h0;
  logic [21:0] pin_in, pin_out, pin_oe, pull_en;
  logic [21:0] ext_val = 22'h0;
  logic [21:0] ext_en = 22'h0;
  logic        wake_req, lvl;
  logic [7:0]  port_a_in;
  int          wake_cnt = 0;
  logic [7:0]  duty [3] = '{8'h00, 8'h4D, 8'hFF};
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          n;
  gpio_ports gpio_ports_i (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_op(mem_op),
    .mem_bit(mem_bit), .mem_rdata(mem_rdata), .timer_ovf(timer_ovf),
    .timer_on(timer_on), .converter_control_cfg(cfg), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .port_a_in(port_a_in),
    .wake_req(wake_req));
  gpio_pins_model gpio_pins_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (wake_req === 1'b1)
      wake_cnt++;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, rmw_op_t op = OP_NONE,
    logic [2:0] b = 3'h0);
    @(negedge clk);
    mem_addr = a;
    mem_wdata = d;
    mem_op = op;
    mem_bit = b;
    mem_wr = 1'b1;
    @(negedge clk);
    mem_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge clk);
    mem_rd = 1'b0;
    check($sformatf("read %h", a), mem_rdata, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    check("oe", pin_oe, 22'h0);
    check("pull", pull_en, 22'h3FFFFF);
    rd(8'h13, 8'hFF);
    rd(8'h17, 8'h03);
    rd(8'h18, 8'h0F);
    rd(8'h1A, 8'h00);
    check("wake idle", wake_cnt, 0);
    ext_val = 22'h0000A5;
    ext_en = 22'h0000FF;
    repeat (6) @(negedge clk);
    rd(8'h12, 8'hA5);
    check("wake", wake_cnt, 1);
    check("port a in", port_a_in, 8'hA5);
    ext_en = 22'h0;
    wr(8'h12, 8'h3C);
    wr(8'h13, 8'h00);
    @(negedge clk);
    check("oe a", pin_oe[7:0], 8'hFF);
    check("out a", pin_out[7:0] & 8'hF7, 8'h34);
    rd(8'h12, 8'h3C);
    wr(8'h12, 8'h00, OP_SET, 3'h0);
    rd(8'h12, 8'h3D);
    wr(8'h12, 8'h00, OP_CLR, 3'h2);
    rd(8'h12, 8'h39);
    wr(8'h12, 8'h00, OP_CPL);
    rd(8'h12, 8'hC6);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    cfg = 3'h3;
    ext_val = 22'h00FF00;
    ext_en = 22'h00FF00;
    repeat (6) @(negedge clk);
    rd(8'h14, 8'hF8);
    check("pull b", pull_en[10:8], 3'h0);
    cfg = 3'h0;
    wr(8'h19, 8'h0E);
    wr(8'h18, 8'h01);
    foreach (duty[k])
    begin
      wr(8'h1A, duty[k]);
      repeat (256) @(negedge clk);
      n = 0;
      repeat (256)
      begin
        @(negedge clk);
        n += int'(pin_out[18] === 1'b1);
      end
      check("pwm high", n, duty[k]);
    end
    wr(8'h18, 8'h00);
    repeat (2) @(negedge clk);
    check("pwm off", pin_out[18], 1'b0);
    wr(8'h12, 8'h08);
    timer_on = 1'b1;
    n = 0;
    repeat (4)
    begin
      lvl = pin_out[3];
      timer_ovf = 1'b1;
      @(negedge clk);
      timer_ovf = 1'b0;
      repeat (8) @(negedge clk);
      n += int'(pin_out[3] !== lvl);
    end
    check("div toggles", n, 4);
    wr(8'h12, 8'h00);
    repeat (2) @(negedge clk);
    check("div gated", pin_out[3], 1'b0);
    end_sim();
  end
  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end
endmodule
bind gpio_ports gpio_ports_monitor gpio_ports_monitor_i (.clk(clk), .sys_rst(sys_rst),
  .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
  .mem_op(mem_op), .mem_rdata(mem_rdata), .converter_control_cfg(converter_control_cfg),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
  .wake_req(wake_req));
`default_nettype wire

// [verif/gpio_ports_monitor.sv]
// Port-level assertions for the I/O port block.
// Assumes a bind to gpio_ports; one clock, sync high reset.
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_monitor
  import gpio_pkg::*;
(
  input wire logic        clk,                   // Clock
  input wire logic        sys_rst,               // Reset
  input wire logic [7:0]  mem_addr,              // Address
  input wire logic        mem_wr,                // Write
  input wire logic [7:0]  mem_wdata,             // Write data
  input wire logic        mem_rd,                // Read
  input wire rmw_op_t     mem_op,                // Bit op
  input wire logic [7:0]  mem_rdata,             // Read data
  input wire logic [2:0]  converter_control_cfg, // Port B field
  input wire logic [21:0] pin_in,                // Pin levels
  input wire logic [21:0] pin_out,               // Drive values
  input wire logic [21:0] pin_oe,                // Drive enables
  input wire logic [21:0] pull_en,               // Pull enables
  input wire logic        wake_req               // Wake pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_dir_wr;
    mem_wr && mem_addr == 8'h13 && mem_op == OP_NONE;
  endsequence
  sequence s_dat_wr;
    mem_wr && mem_addr == 8'h12 && mem_op == OP_NONE;
  endsequence
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> pin_oe == 22'h0 && mem_rdata == 8'h00)
    else $error("outputs not idle after reset");
  AST_DIR_OE: assert property (s_dir_wr |=> ##1 pin_oe[7:0] == ~$past(mem_wdata, 2))
    else $error("port A enables differ from direction");
  AST_LATCH_OUT: assert property (s_dat_wr |=> ##1
    ((pin_out[2:0] ^ $past(mem_wdata[2:0], 2)) & pin_oe[2:0]) == 3'h0)
    else $error("port A drive differs from latch");
  AST_RDATA_HOLD: assert property (!mem_rd |=> $stable(mem_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (mem_rd && (mem_addr < 8'h12 || mem_addr > 8'h1A)
    |=> mem_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_PORTC_MASK: assert property (mem_rd && mem_addr inside {8'h16, 8'h17}
    |=> mem_rdata[7:2] == 6'h0)
    else $error("port C upper bits not zero");
  AST_ANALOG: assert property ((converter_control_cfg != 3'h0) [*2]
    |-> !pin_oe[8] && !pull_en[8])
    else $error("analog line still driven or pulled");
  AST_WAKE: assert property ($changed(pin_in[7:0]) |-> ##[1:8] wake_req)
    else $error("no wake after port A change");
endmodule
`default_nettype wire
